// file: common/asy_pkg.sv
// Notes on behaviour
// - async writes land after two oscillator edges
// - each of five registers has own buffer
// - busy flags show per-register transfer completion
// - compare match suppressed while count/compare pending
// - sleep inside same oscillator cycle re-wakes
// - oscillator runs when selected, except power-down and standby
// - wake starts on next timer clock cycle
// - processor held four cycles after wake
// - count read from shadow refreshed per edge
// - shadow keeps pre-sleep count until edge
// - flags reach core after three cycles plus tick when oscillator-clocked
// - compare pin changes on timer clock only
// - system clock default, oscillator when selected
// - stop, /1, /8, /32, /64, /128, /256, /1024
// - prescaler reset control clears division chain
package asy_pkg;
    localparam int unsigned NUM_REGS    = 5;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned PRESC_W     = 10;
    // register indices
    localparam logic [2:0]  REG_COUNT   = 3'h0;
    localparam logic [2:0]  REG_CMP_A   = 3'h1;
    localparam logic [2:0]  REG_CMP_B   = 3'h2;
    localparam logic [2:0]  REG_CTRL_A  = 3'h3;
    localparam logic [2:0]  REG_CTRL_B  = 3'h4;
    // field positions
    localparam int unsigned CS_LSB      = 0;
    localparam int unsigned TGL_A_BIT   = 6;
    localparam int unsigned TGL_B_BIT   = 4;
    localparam logic [7:0]  RESET_VAL   = 8'h00;
    // timing
    localparam int unsigned XFER_EDGES  = 2;
    localparam int unsigned HALT_CYCLES = 4;
    localparam int unsigned FLAG_SYNC   = 3;
    // sleep modes
    localparam logic [2:0]  SLP_PWR_DOWN = 3'h2;
    localparam logic [2:0]  SLP_STANDBY  = 3'h6;
    // prescaler masks per clock select
    localparam logic [9:0]  MASK_1      = 10'h000;
    localparam logic [9:0]  MASK_8      = 10'h007;
    localparam logic [9:0]  MASK_32     = 10'h01F;
    localparam logic [9:0]  MASK_64     = 10'h03F;
    localparam logic [9:0]  MASK_128    = 10'h07F;
    localparam logic [9:0]  MASK_256    = 10'h0FF;
    localparam logic [9:0]  MASK_1024   = 10'h3FF;
endpackage : asy_pkg

// file: src/asy_hold_buf.sv
`timescale 1ns/1ps
module asy_hold_buf #(
    parameter int unsigned DW    = 8,
    parameter int unsigned EDGES = 2
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // control
    input  wire logic          async_i,
    input  wire logic          wr_i,
    input  wire logic [DW-1:0] data_i,
    input  wire logic          edge_i,
    // results
    output logic               busy_o,
    output logic               load_o,
    output logic [DW-1:0]      data_o
);
    logic [1:0] cnt_r;
    wire        last_edge = busy_o && edge_i && (cnt_r == 2'(EDGES - 1));

    // a new write restarts the transfer and wins over completion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            load_o <= 1'b0;
            cnt_r  <= 2'h0;
            data_o <= '0;
        end else if (wr_i) begin
            data_o <= data_i;
            busy_o <= async_i;
            load_o <= !async_i;
            cnt_r  <= 2'h0;
        end else begin
            load_o <= last_edge;
            if (last_edge) begin
                busy_o <= 1'b0;
            end
            if (busy_o && edge_i) begin
                cnt_r <= cnt_r + 2'h1;
            end
        end
    end
endmodule : asy_hold_buf

// file: src/asy_timer_sync.sv
`timescale 1ns/1ps
module asy_timer_sync #(
    parameter int unsigned DW = asy_pkg::DATA_W
) (
    // clock and reset
    input  wire logic          CLK_I,
    input  wire logic          SYS_RST_I,
    // register writes from the core
    input  wire logic          WR_STB_I,
    input  wire logic [2:0]    WR_SEL_I,
    input  wire logic [DW-1:0] WR_DATA_I,
    // control bits
    input  wire logic          ASYNC_SEL_I,
    input  wire logic          PRESC_RST_I,
    input  wire logic [1:0]    CMP_IRQ_EN_I,
    input  wire logic          OVF_IRQ_EN_I,
    input  wire logic [2:0]    FLAG_CLR_I,
    // sleep controller
    input  wire logic          SLEEP_I,
    input  wire logic [2:0]    SLEEP_MODE_I,
    // oscillator pin
    input  wire logic          OSC_IN_I,
    // status and data
    output logic [DW-1:0]      COUNT_RD_O,
    output logic [4:0]         BUSY_O,
    output logic [2:0]         FLAG_O,
    output logic [1:0]         CMP_PIN_O,
    // power and wake
    output logic               WAKE_O,
    output logic               CPU_HALT_O,
    output logic               OSC_RUN_O,
    output logic               OSC_DETACH_O,
    output logic               SRC_IS_OSC_O
);
    localparam int unsigned N = asy_pkg::NUM_REGS;

    logic [2:0]               osc_sync_r;
    logic                     osc_lvl_r;
    logic [DW-1:0]            dest_r [N];
    logic [DW-1:0]            buf_data [N];
    logic [N-1:0]             busy;
    logic [N-1:0]             load;
    logic [asy_pkg::PRESC_W-1:0] presc_r;
    logic [2:0]               evt_pipe_r [asy_pkg::FLAG_SYNC];
    logic                     wake_pend_r;
    logic                     wake_hold_r;
    logic [2:0]               halt_cnt_r;

    // oscillator edge once the 2nd and 3rd stages agree high
    wire osc_rise = osc_sync_r[1] && osc_sync_r[2] && !osc_lvl_r;
    wire src_tick = ASYNC_SEL_I ? osc_rise : 1'b1;
    wire [2:0] clk_sel = dest_r[asy_pkg::REG_CTRL_B][asy_pkg::CS_LSB +: 3];

    // prescaler tap selection
    logic [9:0] mask;
    always_comb begin
        case (clk_sel)
            3'h1:    mask = asy_pkg::MASK_1;
            3'h2:    mask = asy_pkg::MASK_8;
            3'h3:    mask = asy_pkg::MASK_32;
            3'h4:    mask = asy_pkg::MASK_64;
            3'h5:    mask = asy_pkg::MASK_128;
            3'h6:    mask = asy_pkg::MASK_256;
            3'h7:    mask = asy_pkg::MASK_1024;
            default: mask = asy_pkg::MASK_1;
        endcase
    end
    wire tick = (clk_sel != 3'h0) && src_tick && ((presc_r & mask) == mask);

    // compare detection, blocked while count or compare transfer pends
    wire cnt_pend = busy[asy_pkg::REG_COUNT];
    wire match_a  = tick && !cnt_pend && !busy[asy_pkg::REG_CMP_A]
                    && (dest_r[asy_pkg::REG_COUNT] == dest_r[asy_pkg::REG_CMP_A]);
    wire match_b  = tick && !cnt_pend && !busy[asy_pkg::REG_CMP_B]
                    && (dest_r[asy_pkg::REG_COUNT] == dest_r[asy_pkg::REG_CMP_B]);
    wire ovf      = tick && !load[asy_pkg::REG_COUNT]
                    && (dest_r[asy_pkg::REG_COUNT] == '1);
    wire [2:0] evt_now = {ovf, match_b, match_a};
    // flags take the synchroniser path only when clocked from the oscillator
    wire [2:0] flag_set = ASYNC_SEL_I ? evt_pipe_r[asy_pkg::FLAG_SYNC-1] : evt_now;
    wire [2:0] irq_en   = {OVF_IRQ_EN_I, CMP_IRQ_EN_I};
    wire       irq_cond = |(flag_set & irq_en);
    wire       deep     = (SLEEP_MODE_I == asy_pkg::SLP_PWR_DOWN)
                          || (SLEEP_MODE_I == asy_pkg::SLP_STANDBY);

    // one holding buffer per buffered register
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_buf
            asy_hold_buf #(
                .DW    (DW),
                .EDGES (asy_pkg::XFER_EDGES)
            ) u_buf (
                .clk_i  (CLK_I),
                .rst_i  (SYS_RST_I),
                .async_i(ASYNC_SEL_I),
                .wr_i   (WR_STB_I && (WR_SEL_I == 3'(g))),
                .data_i (WR_DATA_I),
                .edge_i (osc_rise),
                .busy_o (busy[g]),
                .load_o (load[g]),
                .data_o (buf_data[g])
            );

            // destination register, count also advances on timer tick
            always_ff @(posedge CLK_I) begin
                if (SYS_RST_I) begin
                    dest_r[g] <= asy_pkg::RESET_VAL;
                end else if (load[g]) begin
                    dest_r[g] <= buf_data[g];
                end else if ((g == 0) && tick) begin
                    dest_r[g] <= dest_r[g] + DW'(1);
                end
            end
        end
    endgenerate

    // oscillator pin synchroniser, three stages, and the agreed level
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            osc_sync_r <= 3'h0;
            osc_lvl_r  <= 1'b0;
        end else begin
            osc_sync_r <= {osc_sync_r[1:0], OSC_IN_I};
            if (osc_sync_r[1] == osc_sync_r[2]) begin
                osc_lvl_r <= osc_sync_r[2];
            end
        end
    end

    // prescaler chain with software reset
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || PRESC_RST_I) begin
            presc_r <= '0;
        end else if (src_tick) begin
            presc_r <= presc_r + 10'h001;
        end
    end

    // status, shadow count and source outputs
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            BUSY_O       <= 5'h00;
            COUNT_RD_O   <= asy_pkg::RESET_VAL;
            OSC_RUN_O    <= 1'b0;
            OSC_DETACH_O <= 1'b0;
            SRC_IS_OSC_O <= 1'b0;
        end else begin
            BUSY_O       <= busy;
            if (!ASYNC_SEL_I || osc_rise) begin
                COUNT_RD_O <= dest_r[asy_pkg::REG_COUNT];
            end
            OSC_RUN_O    <= ASYNC_SEL_I && !(SLEEP_I && deep);
            OSC_DETACH_O <= ASYNC_SEL_I;
            SRC_IS_OSC_O <= ASYNC_SEL_I;
        end
    end

    // compare pins toggle straight on the timer tick
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            CMP_PIN_O <= 2'h0;
        end else begin
            if (match_a && dest_r[asy_pkg::REG_CTRL_A][asy_pkg::TGL_A_BIT]) begin
                CMP_PIN_O[0] <= !CMP_PIN_O[0];
            end
            if (match_b && dest_r[asy_pkg::REG_CTRL_A][asy_pkg::TGL_B_BIT]) begin
                CMP_PIN_O[1] <= !CMP_PIN_O[1];
            end
        end
    end

    // event flags: three core cycles after the tick when oscillator-clocked, set beats clear
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < asy_pkg::FLAG_SYNC; i++) begin
                evt_pipe_r[i] <= 3'h0;
            end
            FLAG_O <= 3'h0;
        end else begin
            evt_pipe_r[0] <= evt_now;
            for (int i = 1; i < asy_pkg::FLAG_SYNC; i++) begin
                evt_pipe_r[i] <= evt_pipe_r[i-1];
            end
            FLAG_O <= (FLAG_O & ~FLAG_CLR_I) | flag_set;
        end
    end

    // wake sequencing
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            wake_pend_r <= 1'b0;
            wake_hold_r <= 1'b0;
            WAKE_O      <= 1'b0;
            CPU_HALT_O  <= 1'b0;
            halt_cnt_r  <= 3'h0;
        end else begin
            WAKE_O <= 1'b0;
            // hold ends at the next oscillator edge; a wake on this edge re-arms it
            if (osc_rise || !ASYNC_SEL_I) begin
                wake_hold_r <= 1'b0;
            end
            if (SLEEP_I && irq_cond) begin
                wake_pend_r <= 1'b1;
            end else if (wake_pend_r && (tick || !SLEEP_I)) begin
                wake_pend_r <= 1'b0;
                WAKE_O      <= SLEEP_I;
                wake_hold_r <= SLEEP_I && ASYNC_SEL_I;
            end else if (wake_hold_r && SLEEP_I && !osc_rise) begin
                WAKE_O      <= 1'b1;
            end
            if (WAKE_O) begin
                CPU_HALT_O <= 1'b1;
                halt_cnt_r <= 3'(asy_pkg::HALT_CYCLES - 1);
            end else if (halt_cnt_r != 3'h0) begin
                halt_cnt_r <= halt_cnt_r - 3'h1;
            end else begin
                CPU_HALT_O <= 1'b0;
            end
        end
    end
endmodule : asy_timer_sync

// file: dv/asy_timer_sync_props.sv
`timescale 1ns/1ps
module asy_timer_sync_props (
    // clock and reset
    input wire logic       CLK_I,
    input wire logic       SYS_RST_I,
    // watched inputs
    input wire logic       WR_STB_I,
    input wire logic [2:0] WR_SEL_I,
    input wire logic       ASYNC_SEL_I,
    input wire logic [2:0] FLAG_CLR_I,
    input wire logic       SLEEP_I,
    input wire logic [2:0] SLEEP_MODE_I,
    input wire logic       OSC_IN_I,
    // watched outputs
    input wire logic [7:0] COUNT_RD_O,
    input wire logic [4:0] BUSY_O,
    input wire logic [2:0] FLAG_O,
    input wire logic       WAKE_O,
    input wire logic       CPU_HALT_O,
    input wire logic       OSC_RUN_O,
    input wire logic       OSC_DETACH_O,
    input wire logic       SRC_IS_OSC_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // power-down and standby stop the crystal
    wire deep_w = SLEEP_I && (SLEEP_MODE_I == asy_pkg::SLP_PWR_DOWN
                              || SLEEP_MODE_I == asy_pkg::SLP_STANDBY);
    // update-busy behaviour
    a_busy_on_write: assert property (
        ASYNC_SEL_I && WR_STB_I && WR_SEL_I < 3'h5 |-> ##2 BUSY_O[$past(WR_SEL_I, 2)])
        else $error("busy not raised after write");
    a_busy_bounded: assert property (
        $rose(|BUSY_O) |-> ##[1:300] BUSY_O == 5'h00) else $error("busy never clears");
    // wake and halt
    a_halt_after_wake: assert property (
        WAKE_O |=> CPU_HALT_O [*4]) else $error("halt not held four cycles");
    a_wake_asleep: assert property (
        WAKE_O |-> $past(SLEEP_I)) else $error("wake while awake");
    // oscillator run control and source selection
    a_deep_stop: assert property (
        ASYNC_SEL_I && deep_w |=> !OSC_RUN_O) else $error("osc runs in deep sleep");
    a_osc_runs: assert property (
        ASYNC_SEL_I && !SLEEP_I |=> OSC_RUN_O) else $error("osc stopped while awake");
    a_src_follow: assert property (
        1'b1 |=> SRC_IS_OSC_O == $past(ASYNC_SEL_I) && OSC_DETACH_O == $past(ASYNC_SEL_I))
        else $error("source select mismatch");
    // sticky flag and shadow count
    a_flag_sticky: assert property (
        FLAG_O[2] && !FLAG_CLR_I[2] |=> FLAG_O[2]) else $error("flag lost");
    a_shadow_hold: assert property (
        (ASYNC_SEL_I && !OSC_IN_I) [*4] |=> $stable(COUNT_RD_O))
        else $error("shadow moved without osc edge");
endmodule : asy_timer_sync_props

bind asy_timer_sync asy_timer_sync_props u_props (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .WR_STB_I(WR_STB_I), .WR_SEL_I(WR_SEL_I), .ASYNC_SEL_I(ASYNC_SEL_I),
    .FLAG_CLR_I(FLAG_CLR_I), .SLEEP_I(SLEEP_I), .SLEEP_MODE_I(SLEEP_MODE_I),
    .OSC_IN_I(OSC_IN_I), .COUNT_RD_O(COUNT_RD_O), .BUSY_O(BUSY_O), .FLAG_O(FLAG_O),
    .WAKE_O(WAKE_O), .CPU_HALT_O(CPU_HALT_O), .OSC_RUN_O(OSC_RUN_O),
    .OSC_DETACH_O(OSC_DETACH_O), .SRC_IS_OSC_O(SRC_IS_OSC_O));

// file: dv/asy_osc_model.sv
`timescale 1ns/1ps
module asy_osc_model #(
    parameter int unsigned HALF_NS = 210
) (
    // run request from the timer
    input  wire logic run_i,
    // crystal pin
    output logic      osc_o
);
    // crystal halts low whenever it is stopped
    initial begin
        osc_o = 1'b0;
        forever begin
            #(HALF_NS);
            osc_o = run_i ? ~osc_o : 1'b0;
        end
    end
endmodule : asy_osc_model

// file: dv/async_timer_clock_sync_test.sv
`timescale 1ns/1ps
module async_timer_clock_sync_test;
    // stimulus and results
    logic       clk, rst, stb, asel, prst, ovf_en, slp, wake, halt, orun, odet, osrc, osc;
    logic [2:0] sel, fclr, smode, flg;
    logic [7:0] wdat, cnt, s0, s1;
    logic [4:0] busy;
    logic [1:0] cmp_en, pin;
    int         err_count, n_checks, cyc;

    asy_timer_sync dut (.CLK_I(clk), .SYS_RST_I(rst), .WR_STB_I(stb), .WR_SEL_I(sel),
        .WR_DATA_I(wdat), .ASYNC_SEL_I(asel), .PRESC_RST_I(prst), .CMP_IRQ_EN_I(cmp_en),
        .OVF_IRQ_EN_I(ovf_en), .FLAG_CLR_I(fclr), .SLEEP_I(slp), .SLEEP_MODE_I(smode),
        .OSC_IN_I(osc), .COUNT_RD_O(cnt), .BUSY_O(busy), .FLAG_O(flg), .CMP_PIN_O(pin),
        .WAKE_O(wake), .CPU_HALT_O(halt), .OSC_RUN_O(orun), .OSC_DETACH_O(odet),
        .SRC_IS_OSC_O(osrc));
    asy_osc_model xtal (.run_i(orun), .osc_o(osc));

    // core clock and hang guard
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic chk(input logic [7:0] exp, input logic [7:0] got, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s exp %h got %h", $time, what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        stb <= 1'b1;
        sel <= s;
        wdat <= d;
        @(posedge clk);
        stb <= 1'b0;
    endtask : wr
    task automatic wait_idle();
        tick(2);
        for (int i = 0; i < 200 && busy !== 5'h00; i++) tick(1);
        chk(8'h00, {3'h0, busy}, "busy clear");
    endtask : wait_idle
    task automatic rise_sample(output logic [7:0] v);
        @(posedge osc);
        tick(6);
        v = cnt;
    endtask : rise_sample

    task automatic t_source();
        tick(2);
        chk(8'h00, {6'h0, osrc, odet}, "sync source");
        @(posedge clk);
        asel <= 1'b1;
        tick(3);
        chk(8'h07, {5'h0, osrc, odet, orun}, "async source");
        repeat (4) @(posedge osc);
        $display("test source done");
    endtask : t_source
    task automatic t_buffers();
        wr(asy_pkg::REG_CMP_A, 8'h55);
        wr(asy_pkg::REG_CTRL_A, 8'h00);
        tick(2);
        chk(8'h0A, {3'h0, busy}, "own buffers");
        wait_idle();
        $display("test buffers done");
    endtask : t_buffers
    task automatic t_prescale();
        int div [8] = '{16, 1, 8, 32, 64, 128, 256, 1024};
        for (int cs = 0; cs < 8; cs++) begin
            wr(asy_pkg::REG_CTRL_B, 8'(cs));
            wait_idle();
            rise_sample(s0);
            repeat (div[cs] - 1) @(posedge osc);
            rise_sample(s1);
            chk(8'(cs != 0), s1 - s0, "ticks per window");
        end
        wr(asy_pkg::REG_CTRL_B, 8'h02);
        wait_idle();
        @(posedge clk);
        prst <= 1'b1;
        rise_sample(s0);
        repeat (15) @(posedge osc);
        rise_sample(s1);
        chk(8'h00, s1 - s0, "held prescaler");
        @(posedge clk);
        prst <= 1'b0;
        $display("test prescale done");
    endtask : t_prescale
    task automatic t_wake();
        wr(asy_pkg::REG_CTRL_B, 8'h01);
        wr(asy_pkg::REG_COUNT, 8'hF0);
        wait_idle();
        @(posedge clk);
        fclr <= 3'h7;
        ovf_en <= 1'b1;
        smode <= 3'h3;
        @(posedge clk);
        fclr <= 3'h0;
        slp <= 1'b1;
        #1;
        for (int i = 0; i < 600 && wake !== 1'b1; i++) tick(1);
        chk(8'h01, {7'h0, flg[2]}, "overflow flag");
        tick(1);
        chk(8'h01, {7'h0, halt}, "halt after wake");
        for (int i = 0; i < 3 && wake !== 1'b1; i++) tick(1);
        chk(8'h01, {7'h0, wake}, "repeat wake");
        @(posedge clk);
        slp <= 1'b0;
        fclr <= 3'h7;
        ovf_en <= 1'b0;
        @(posedge clk);
        fclr <= 3'h0;
        $display("test wake done");
    endtask : t_wake
    task automatic t_deep();
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            smode <= m ? asy_pkg::SLP_STANDBY : asy_pkg::SLP_PWR_DOWN;
            slp <= 1'b1;
            tick(3);
            chk(8'h00, {7'h0, orun}, "osc in deep sleep");
            @(posedge clk);
            slp <= 1'b0;
            tick(3);
            chk(8'h01, {7'h0, orun}, "osc after wake");
        end
        $display("test deep sleep done");
    endtask : t_deep
    task automatic t_compare();
        wr(asy_pkg::REG_CTRL_B, 8'h00);
        wait_idle();
        wr(asy_pkg::REG_CTRL_A, 8'h50);
        wr(asy_pkg::REG_CMP_A, 8'h10);
        wr(asy_pkg::REG_CMP_B, 8'h40);
        wr(asy_pkg::REG_COUNT, 8'h00);
        wait_idle();
        wr(asy_pkg::REG_CTRL_B, 8'h01);
        wait_idle();
        rise_sample(s0);
        for (int i = 0; i < 100 && s0 !== 8'h3E; i++) rise_sample(s0);
        chk(8'h3E, s0, "count before match");
        chk(8'h01, {6'h0, pin}, "pin A toggled");
        wr(asy_pkg::REG_COUNT, 8'hA0);
        wait_idle();
        chk(8'h01, {6'h0, pin}, "match held off");
        $display("test compare done");
    endtask : t_compare

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // reset, then the scenarios in order
    initial begin
        {rst, stb, asel, prst, ovf_en, slp, sel, fclr, smode, wdat, cmp_en} = '0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_source();
        t_buffers();
        t_prescale();
        t_wake();
        t_deep();
        t_compare();
        complete_run();
    end
endmodule : async_timer_clock_sync_test
